// file: rtl/aal_alarm_alert.sv
// Alarm aggregation with mask, sticky flags and open-drain alert output.
//
// Functional notes
// - Alert pin driven low while the alarm is active, released otherwise.
// - Alarm is the OR of all latched event flags.
// - Mask word bit decides whether each raw flag, or for the charger its changed flag, may raise the alarm.
// - Raw flags word reads current unlatched sources, ignoring the mask.
// - Four summary flags show any bit set in the four safety words.
// - Charge-switch-off flag high while the charge driver is off.
// - Discharge-switch-off flag high while the discharge driver is off.
// - Low-voltage flag high when stack or any cell is below shutdown.
// - Balancing flag high while cell balancing runs.
// - Full-scan flag pulses when a complete measurement loop finishes.
// - Single-scan flag pulses when one voltage and current scan finishes.
// - Wake flag set when the device is woken from sleep.
// - Sleep flag pulses on entry to sleep.
// - Timer flag pulses when the programmable timer expires.
// - Init flag pulses when the startup measurement sequence finishes.
// - Charger raw flag follows the undebounced charger detector.
// - Charger changed flag latches when debounced level leaves last state.
// - Masked-in raw flag other than charger sets its latched bit, which stays set until a one is written to it.
// - Mask loads its stored default at reset and is host writable.
`timescale 1ns/1ps
module aal_alarm_alert (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Avalon-MM register slave
  input wire logic [aal_pkg::AAL_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [aal_pkg::AAL_DATA_W-1:0] i_avs_writedata,
  input wire logic [aal_pkg::AAL_BE_W-1:0] i_avs_byteenable,
  output logic [aal_pkg::AAL_DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Safety words to summarise
  input wire logic [aal_pkg::AAL_SAFETY_W-1:0] i_safety_status_a,
  input wire logic [aal_pkg::AAL_SAFETY_W-1:0] i_safety_status_b,
  input wire logic [aal_pkg::AAL_SAFETY_W-1:0] i_safety_alert_a,
  input wire logic [aal_pkg::AAL_SAFETY_W-1:0] i_safety_alert_b,
  // Condition levels
  input wire logic i_charge_driver_on,
  input wire logic i_discharge_driver_on,
  input wire logic i_stack_below_shutdown,
  input wire logic i_cell_below_shutdown,
  input wire logic i_balancing_active,
  // Event pulses
  input wire logic i_full_scan_done,
  input wire logic i_single_scan_done,
  input wire logic i_wake_event,
  input wire logic i_sleep_entry,
  input wire logic i_timer_expired,
  input wire logic i_init_complete,
  // Charger detector comparator, asynchronous
  input wire logic i_charger_detect_pin,
  // Open-drain alert pin
  output logic o_alert_out,
  output logic o_alert_oe
);
  import aal_pkg::*;

  logic [AAL_FLAG_W-1:0] latched_event_flags;
  logic [AAL_FLAG_W-1:0] instantaneous_event_flags;
  logic [AAL_FLAG_W-1:0] event_mask;
  logic [AAL_FLAG_W-1:0] set_bits;
  logic [AAL_FLAG_W-1:0] clear_bits;
  logic [AAL_FLAG_W-1:0] next_latched;
  logic [AAL_FLAG_W-1:0] lane_mask;
  logic [AAL_FLAG_W-1:0] next_mask;
  logic [AAL_DATA_W-1:0] next_readdata;
  logic charger_detect_raw;
  logic charger_detect_level;
  logic charger_detect_prev;
  logic charger_detect_changed;
  logic req_take;
  logic wr_latched;
  logic wr_mask;

  // Comparator output enters the clock domain, then is debounced.
  aal_sync u_charger_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_charger_detect_pin),
    .o_level(charger_detect_raw)
  );

  aal_debounce u_charger_debounce (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_level(charger_detect_raw),
    .o_level(charger_detect_level)
  );

  // Instantaneous flags, independent of the mask.
  always_comb begin
    instantaneous_event_flags = AAL_FLAGS_RESET;
    instantaneous_event_flags[AAL_BIT_FAULT_A] = |i_safety_status_a;
    instantaneous_event_flags[AAL_BIT_FAULT_B] = |i_safety_status_b;
    instantaneous_event_flags[AAL_BIT_WARN_A] = |i_safety_alert_a;
    instantaneous_event_flags[AAL_BIT_WARN_B] = |i_safety_alert_b;
    instantaneous_event_flags[AAL_BIT_CHG_OFF] = !i_charge_driver_on;
    instantaneous_event_flags[AAL_BIT_DSG_OFF] = !i_discharge_driver_on;
    instantaneous_event_flags[AAL_BIT_LOW_V] =
      i_stack_below_shutdown | i_cell_below_shutdown;
    instantaneous_event_flags[AAL_BIT_BALANCE] = i_balancing_active;
    instantaneous_event_flags[AAL_BIT_FULL_SCAN] = i_full_scan_done;
    instantaneous_event_flags[AAL_BIT_SINGLE_SCAN] = i_single_scan_done;
    instantaneous_event_flags[AAL_BIT_WAKE] = i_wake_event;
    instantaneous_event_flags[AAL_BIT_SLEEP] = i_sleep_entry;
    instantaneous_event_flags[AAL_BIT_TIMER] = i_timer_expired;
    instantaneous_event_flags[AAL_BIT_INIT] = i_init_complete;
    instantaneous_event_flags[AAL_BIT_CHARGER] = charger_detect_raw;
  end

  // The latched charger bit records a change of the debounced level
  // against the level seen last, not the raw level itself.
  assign charger_detect_changed =
    charger_detect_level != charger_detect_prev;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      charger_detect_prev <= 1'b0;
    end else begin
      charger_detect_prev <= charger_detect_level;
    end
  end

  // Bus decode; a request is taken once, in the cycle before the answer.
  assign req_take = (i_avs_read | i_avs_write) & o_avs_waitrequest;
  assign wr_latched = req_take & i_avs_write &
    (i_avs_address == AAL_ADDR_LATCHED);
  assign wr_mask = req_take & i_avs_write &
    (i_avs_address == AAL_ADDR_MASK);
  assign lane_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // Sources that may set a latched bit, gated by the mask.
  always_comb begin
    set_bits = instantaneous_event_flags;
    set_bits[AAL_BIT_CHARGER] = charger_detect_changed;
    set_bits = set_bits & event_mask & AAL_FLAG_USED;
  end

  assign clear_bits = wr_latched ?
    (i_avs_writedata[AAL_FLAG_W-1:0] & lane_mask) : AAL_FLAGS_RESET;

  // Set is applied after the clear so that a colliding event survives.
  assign next_latched =
    ((latched_event_flags & ~clear_bits) | set_bits) & AAL_FLAG_USED;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      latched_event_flags <= AAL_FLAGS_RESET;
    end else begin
      latched_event_flags <= next_latched;
    end
  end

  assign next_mask = ((event_mask & ~lane_mask) |
    (i_avs_writedata[AAL_FLAG_W-1:0] & lane_mask)) & AAL_FLAG_USED;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      event_mask <= AAL_MASK_DEFAULT;
    end else if (wr_mask) begin
      event_mask <= next_mask;
    end
  end

  // The pin enable is computed from the next flag word so that it stays
  // in step with the latched word, with no extra cycle of lag.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_alert_oe <= 1'b0;
      o_alert_out <= 1'b0;
    end else begin
      o_alert_oe <= |next_latched;
      o_alert_out <= 1'b0;
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    next_readdata = AAL_DATA_ZERO;
    case (i_avs_address)
      AAL_ADDR_LATCHED: begin
        next_readdata[AAL_FLAG_W-1:0] = latched_event_flags;
      end
      AAL_ADDR_RAW: begin
        next_readdata[AAL_FLAG_W-1:0] = instantaneous_event_flags;
      end
      AAL_ADDR_MASK: begin
        next_readdata[AAL_FLAG_W-1:0] = event_mask;
      end
      default: begin
        next_readdata = AAL_DATA_ZERO;
      end
    endcase
  end

  // Every access gets exactly one wait cycle, then one answer cycle.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= AAL_DATA_ZERO;
    end else if (req_take) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= i_avs_read ? next_readdata : AAL_DATA_ZERO;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  default clocking dclk @(posedge i_clk);
  endclocking

  default disable iff (i_reset);

  a_alert_drive:
  assert property (o_alert_oe |-> !o_alert_out)
    else $error("Alert enabled while not driving low.");

  a_alarm_or_flags:
  assert property (o_alert_oe == (latched_event_flags != AAL_FLAGS_RESET))
    else $error("Alert enable differs from OR of latched flags.");

  a_mask_gates_set:
  assert property (1'b1 |=> ((latched_event_flags &
    ~$past(latched_event_flags) & ~$past(event_mask)) == AAL_FLAGS_RESET))
    else $error("Masked-out flag became latched.");

  a_raw_read_value:
  assert property ((req_take && i_avs_read &&
    i_avs_address == AAL_ADDR_RAW) |=> (!o_avs_waitrequest &&
    o_avs_readdata[AAL_FLAG_W-1:0] == $past(instantaneous_event_flags)))
    else $error("Raw flag read returned wrong value.");

  a_fault_a_latch:
  assert property ((|i_safety_status_a && event_mask[AAL_BIT_FAULT_A])
    |=> (latched_event_flags[AAL_BIT_FAULT_A] && o_alert_oe))
    else $error("Safety status summary did not latch and alert.");

  a_chg_off_latch:
  assert property ((!i_charge_driver_on && event_mask[AAL_BIT_CHG_OFF])
    |=> latched_event_flags[AAL_BIT_CHG_OFF])
    else $error("Charge switch off did not latch.");

  a_dsg_off_latch:
  assert property ((!i_discharge_driver_on && event_mask[AAL_BIT_DSG_OFF])
    |=> latched_event_flags[AAL_BIT_DSG_OFF])
    else $error("Discharge switch off did not latch.");

  a_low_volt_latch:
  assert property ((i_cell_below_shutdown && event_mask[AAL_BIT_LOW_V])
    |=> latched_event_flags[AAL_BIT_LOW_V])
    else $error("Low voltage shutdown did not latch.");

  a_timer_pulse_hold:
  assert property ((i_timer_expired && event_mask[AAL_BIT_TIMER]) ##1
    !wr_latched [*3] |=> latched_event_flags[AAL_BIT_TIMER])
    else $error("Timer flag not held after its pulse.");

  a_charger_toggle:
  assert property ((charger_detect_changed &&
    event_mask[AAL_BIT_CHARGER]) |=> latched_event_flags[AAL_BIT_CHARGER])
    else $error("Charger level change did not latch.");

  a_latch_holds:
  assert property (1'b1 |=> ((~latched_event_flags &
    $past(latched_event_flags) & ~$past(clear_bits)) == AAL_FLAGS_RESET))
    else $error("Latched flag fell without a clear.");

  a_w1c_clears:
  assert property (wr_latched |=> ((latched_event_flags &
    $past(clear_bits) & ~$past(set_bits)) == AAL_FLAGS_RESET))
    else $error("Write one did not clear latched flag.");

  a_mask_default:
  assert property (disable iff (1'b0)
    i_reset |=> event_mask == AAL_MASK_DEFAULT)
    else $error("Mask not at stored default after reset.");

  a_set_wins_clear:
  assert property (((set_bits & clear_bits) != AAL_FLAGS_RESET) |=>
    ((latched_event_flags & $past(set_bits & clear_bits)) ==
    $past(set_bits & clear_bits)))
    else $error("Clear beat a same-cycle set.");

  a_bus_one_wait:
  assert property (req_take |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("Bus answer not exactly one cycle after request.");

  a_balance_latch:
  assert property ((i_balancing_active && event_mask[AAL_BIT_BALANCE])
    |=> latched_event_flags[AAL_BIT_BALANCE])
    else $error("Balancing flag did not latch.");

  a_full_scan_latch:
  assert property ((i_full_scan_done && event_mask[AAL_BIT_FULL_SCAN])
    |=> latched_event_flags[AAL_BIT_FULL_SCAN])
    else $error("Full scan flag did not latch.");

  a_single_scan_latch:
  assert property ((i_single_scan_done && event_mask[AAL_BIT_SINGLE_SCAN])
    |=> latched_event_flags[AAL_BIT_SINGLE_SCAN])
    else $error("Single scan flag did not latch.");

  a_wake_latch:
  assert property ((i_wake_event && event_mask[AAL_BIT_WAKE])
    |=> latched_event_flags[AAL_BIT_WAKE])
    else $error("Wake flag did not latch.");

  a_sleep_latch:
  assert property ((i_sleep_entry && event_mask[AAL_BIT_SLEEP])
    |=> latched_event_flags[AAL_BIT_SLEEP])
    else $error("Sleep entry flag did not latch.");

  a_init_latch:
  assert property ((i_init_complete && event_mask[AAL_BIT_INIT])
    |=> latched_event_flags[AAL_BIT_INIT])
    else $error("Init complete flag did not latch.");

  a_charger_raw_read:
  assert property ((req_take && i_avs_read &&
    i_avs_address == AAL_ADDR_RAW) |=>
    (o_avs_readdata[AAL_BIT_CHARGER] == $past(charger_detect_raw)))
    else $error("Charger raw flag read differs from detector level.");

  a_charger_quiet:
  assert property ((!charger_detect_changed &&
    !latched_event_flags[AAL_BIT_CHARGER]) |=>
    !latched_event_flags[AAL_BIT_CHARGER])
    else $error("Charger flag latched without a level change.");

  c_alert_rises:
  cover property (!o_alert_oe ##1 o_alert_oe);

  c_set_clear_collide:
  cover property ((set_bits & clear_bits) != AAL_FLAGS_RESET);

  c_charger_latched:
  cover property (charger_detect_changed && event_mask[AAL_BIT_CHARGER]);

  c_alert_cleared:
  cover property (o_alert_oe ##1 wr_latched ##1 !o_alert_oe);

  c_mask_written:
  cover property (wr_mask);

endmodule

// file: rtl/aal_debounce.sv
// Debouncer that passes a level once it has held for the debounce time.
`timescale 1ns/1ps
module aal_debounce (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Synchronised level in, debounced level out
  input wire logic i_level,
  output logic o_level
);
  import aal_pkg::*;

  localparam logic [AAL_DEB_W-1:0] DEB_LAST =
    AAL_DEB_W'(AAL_DEBOUNCE_CYC - 1);

  logic [AAL_DEB_W-1:0] hold_count;

  // Any return to the present level restarts the hold time.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      hold_count <= '0;
      o_level <= 1'b0;
    end else if (i_level == o_level) begin
      hold_count <= '0;
    end else if (hold_count == DEB_LAST) begin
      hold_count <= '0;
      o_level <= i_level;
    end else begin
      hold_count <= hold_count + 1'b1;
    end
  end

endmodule

// file: rtl/aal_pkg.sv
// Constants shared by the alarm and alert logic.
package aal_pkg;

  // Avalon-MM slave geometry; the address is a byte address.
  localparam int AAL_ADDR_W = 10;
  localparam int AAL_DATA_W = 32;
  localparam int AAL_BE_W = 4;

  // Flag word geometry and width of each safety word summarised.
  localparam int AAL_FLAG_W = 16;
  localparam int AAL_SAFETY_W = 8;

  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] AAL_IDX_LATCHED = 8'h62;
  localparam logic [7:0] AAL_IDX_RAW = 8'h64;
  localparam logic [7:0] AAL_IDX_MASK = 8'h66;
  localparam logic [AAL_ADDR_W-1:0] AAL_ADDR_LATCHED = {AAL_IDX_LATCHED, 2'h0};
  localparam logic [AAL_ADDR_W-1:0] AAL_ADDR_RAW = {AAL_IDX_RAW, 2'h0};
  localparam logic [AAL_ADDR_W-1:0] AAL_ADDR_MASK = {AAL_IDX_MASK, 2'h0};

  // Bit positions inside the three flag words.
  localparam int AAL_BIT_FAULT_A = 0;
  localparam int AAL_BIT_FAULT_B = 1;
  localparam int AAL_BIT_WARN_A = 2;
  localparam int AAL_BIT_WARN_B = 3;
  localparam int AAL_BIT_CHG_OFF = 4;
  localparam int AAL_BIT_DSG_OFF = 5;
  localparam int AAL_BIT_LOW_V = 6;
  localparam int AAL_BIT_BALANCE = 7;
  localparam int AAL_BIT_FULL_SCAN = 8;
  localparam int AAL_BIT_SINGLE_SCAN = 9;
  localparam int AAL_BIT_WAKE = 10;
  localparam int AAL_BIT_SLEEP = 11;
  localparam int AAL_BIT_TIMER = 12;
  localparam int AAL_BIT_INIT = 13;
  localparam int AAL_BIT_CHARGER = 14;

  // Implemented bits, stored default mask and reset values.
  localparam logic [AAL_FLAG_W-1:0] AAL_FLAG_USED = 16'h7FFF;
  localparam logic [AAL_FLAG_W-1:0] AAL_MASK_DEFAULT = 16'h0000;
  localparam logic [AAL_FLAG_W-1:0] AAL_FLAGS_RESET = 16'h0000;
  localparam logic [AAL_DATA_W-1:0] AAL_DATA_ZERO = 32'h00000000;

  // Charger detector debounce time and its length in clock cycles.
  localparam int AAL_CLK_HZ = 25000000;
  localparam int AAL_DEBOUNCE_US = 100;
  localparam int AAL_DEBOUNCE_CYC = (AAL_CLK_HZ / 1000000) * AAL_DEBOUNCE_US;
  localparam int AAL_DEB_W = 12;

endpackage

// file: rtl/aal_sync.sv
// Three-stage pin synchroniser that accepts a change once two stages agree.
`timescale 1ns/1ps
module aal_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Asynchronous level in, clean level out
  input wire logic i_pin,
  output logic o_level
);
  import aal_pkg::*;

  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_level <= 1'b0;
    end else if (stage2 == stage3) begin
      o_level <= stage3;
    end
  end

endmodule

// file: testbench/aal_host_model.sv
// Host side of the alert line: pull-up wire and interrupt sampler.
`timescale 1ns/1ps
module aal_host_model (
  // Clock
  input wire logic i_clk,
  // Open-drain pin as driven by the device
  input wire logic i_alert_out,
  input wire logic i_alert_oe,
  // Resolved wire and interrupt seen by the host
  output logic o_alert_n,
  output logic o_irq
);
  // The board pull-up holds the wire high whenever the device releases it.
  assign o_alert_n = i_alert_oe ? i_alert_out : 1'b1;
  always_ff @(posedge i_clk) begin
    o_irq <= ~o_alert_n;
  end
endmodule

// file: testbench/alarm_alert_logic_bench.sv
// Self-checking testbench for the alarm and alert logic.
`timescale 1ns/1ps
module alarm_alert_logic_bench;
  import aal_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [AAL_ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [AAL_DATA_W-1:0] wdata = '0;
  logic [AAL_BE_W-1:0] be = '0;
  logic [AAL_BE_W-1:0] be_sel = 4'hF;
  logic [AAL_DATA_W-1:0] rdata;
  logic waitreq, alert_out, alert_oe, alert_n, irq;
  logic [7:0] ss_a = '0, ss_b = '0, sa_a = '0, sa_b = '0;
  logic chg_on = 1'b1, dsg_on = 1'b1, stk_low = 1'b0, cell_low = 1'b0;
  logic bal = 1'b0, chg_pin = 1'b0;
  logic [5:0] ev = '0;
  int err_count = 0;
  int checks = 0;
  logic [31:0] rv;
  logic [15:0] exp_lv [9] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
    16'h0010, 16'h0020, 16'h0040, 16'h0040, 16'h0080};

  always #20 i_clk = ~i_clk;

  aal_alarm_alert aal_alarm_alert_inst (.i_clk(i_clk), .i_reset(i_reset),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_safety_status_a(ss_a), .i_safety_status_b(ss_b),
    .i_safety_alert_a(sa_a), .i_safety_alert_b(sa_b),
    .i_charge_driver_on(chg_on), .i_discharge_driver_on(dsg_on),
    .i_stack_below_shutdown(stk_low), .i_cell_below_shutdown(cell_low),
    .i_balancing_active(bal), .i_full_scan_done(ev[0]),
    .i_single_scan_done(ev[1]), .i_wake_event(ev[2]),
    .i_sleep_entry(ev[3]), .i_timer_expired(ev[4]),
    .i_init_complete(ev[5]), .i_charger_detect_pin(chg_pin),
    .o_alert_out(alert_out), .o_alert_oe(alert_oe));

  aal_host_model aal_host_model_inst (.i_clk(i_clk),
    .i_alert_out(alert_out), .i_alert_oe(alert_oe),
    .o_alert_n(alert_n), .o_irq(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [AAL_ADDR_W-1:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    be <= be_sel;
    @(posedge i_clk);
    while (waitreq !== 1'b0) begin
      n++;
      @(posedge i_clk);
    end
    check(32'(n), 32'h1);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [AAL_ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [AAL_ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask

  task automatic pulse(input int k);
    @(posedge i_clk);
    ev[k] <= 1'b1;
    @(posedge i_clk);
    ev <= '0;
  endtask

  task automatic set_level(input int k, input logic v);
    case (k)
      0: ss_a <= v ? 8'h80 : 8'h00;
      1: ss_b <= {7'h00, v};
      2: sa_a <= v ? 8'h10 : 8'h00;
      3: sa_b <= v ? 8'h02 : 8'h00;
      4: chg_on <= !v;
      5: dsg_on <= !v;
      6: stk_low <= v;
      7: cell_low <= v;
      default: bal <= v;
    endcase
  endtask

  task automatic t_reset();
    rd_chk(AAL_ADDR_MASK, {16'h0000, AAL_MASK_DEFAULT});
    rd_chk(AAL_ADDR_LATCHED, 32'h0);
    rd_chk(AAL_ADDR_RAW, 32'h0);
    check({31'h0, alert_n}, 32'h1);
    wr_reg(AAL_ADDR_RAW, 32'h0000FFFF);
    rd_chk(AAL_ADDR_RAW, 32'h0);
    wr_reg(10'h004, 32'h0000FFFF);
    rd_chk(10'h004, 32'h0);
    wr_reg(AAL_ADDR_MASK, 32'h0000A5C3);
    rd_chk(AAL_ADDR_MASK, 32'h000025C3);
    be_sel = 4'h1;
    wr_reg(AAL_ADDR_MASK, 32'h0000FFFF);
    be_sel = 4'hF;
    rd_chk(AAL_ADDR_MASK, 32'h000025FF);
    wr_reg(AAL_ADDR_MASK, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_levels();
    for (int k = 0; k < 9; k++) begin
      set_level(k, 1'b1);
      tick(2);
      rd_chk(AAL_ADDR_RAW, {16'h0, exp_lv[k]});
      rd_chk(AAL_ADDR_LATCHED, 32'h0);
      wr_reg(AAL_ADDR_MASK, {16'h0, exp_lv[k]});
      rd_chk(AAL_ADDR_LATCHED, {16'h0, exp_lv[k]});
      check({31'h0, alert_n}, 32'h0);
      set_level(k, 1'b0);
      wr_reg(AAL_ADDR_LATCHED, {16'h0, exp_lv[k]});
      rd_chk(AAL_ADDR_LATCHED, 32'h0);
      wr_reg(AAL_ADDR_MASK, 32'h0);
    end
    $display("test levels done");
  endtask

  task automatic t_pulses();
    wr_reg(AAL_ADDR_MASK, 32'h00007FFF);
    for (int k = 0; k < 6; k++) begin
      pulse(k);
      tick(2);
      rv = 32'h1 << (8 + k);
      rd_chk(AAL_ADDR_LATCHED, rv);
      check({31'h0, alert_n}, 32'h0);
      check({31'h0, irq}, 32'h1);
      wr_reg(AAL_ADDR_LATCHED, 32'h1 << (8 + k));
      rd_chk(AAL_ADDR_LATCHED, 32'h0);
      check({31'h0, alert_n}, 32'h1);
    end
    $display("test pulses done");
  endtask

  task automatic t_mask();
    wr_reg(AAL_ADDR_MASK, 32'h00001000);
    pulse(3);
    pulse(4);
    tick(2);
    rd_chk(AAL_ADDR_LATCHED, 32'h00001000);
    rd_chk(AAL_ADDR_RAW, 32'h0);
    fork
      pulse(4);
      wr_reg(AAL_ADDR_LATCHED, 32'h00001000);
    join
    rd_chk(AAL_ADDR_LATCHED, 32'h00001000);
    wr_reg(AAL_ADDR_LATCHED, 32'h00001000);
    rd_chk(AAL_ADDR_LATCHED, 32'h0);
    $display("test mask done");
  endtask

  task automatic t_charger();
    wr_reg(AAL_ADDR_MASK, 32'h00004000);
    chg_pin <= 1'b1;
    tick(6);
    rd_chk(AAL_ADDR_RAW, 32'h00004000);
    rd_chk(AAL_ADDR_LATCHED, 32'h0);
    tick(AAL_DEBOUNCE_CYC + 20);
    rd_chk(AAL_ADDR_LATCHED, 32'h00004000);
    wr_reg(AAL_ADDR_LATCHED, 32'h00004000);
    rd_chk(AAL_ADDR_LATCHED, 32'h0);
    chg_pin <= 1'b0;
    tick(AAL_DEBOUNCE_CYC + 20);
    rd_chk(AAL_ADDR_RAW, 32'h0);
    rd_chk(AAL_ADDR_LATCHED, 32'h00004000);
    wr_reg(AAL_ADDR_LATCHED, 32'h00004000);
    $display("test charger done");
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    $display("[FAIL] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_levels();
    t_pulses();
    t_mask();
    t_charger();
    end_of_test();
  end
endmodule
